// >>> tpc_timer2_regs.vh
// Purpose: register map, field positions and constants of the timer2 counter core
// Assumes: byte-wide cpu data bus, data-space addresses
// Notes: definitions only
`ifndef TPC_TIMER2_REGS_VH
`define TPC_TIMER2_REGS_VH

// data-space addresses; i/o instructions see them lowered by the offset below
`define TPC_IO_OFS 8'h20
`define TPC_SYNCRST_ADDR 8'h43
`define TPC_CTLA_ADDR 8'hD0
`define TPC_CTLB_ADDR 8'hD1
`define TPC_CNT_ADDR 8'hD2
`define TPC_CMPA_ADDR 8'hD3
`define TPC_CMPB_ADDR 8'hD4
`define TPC_ASTAT_ADDR 8'hD5
`define TPC_FLAG_ADDR 8'hD6
`define TPC_MASK_ADDR 8'hD7

`define TPC_RESET_VAL 8'h00
`define TPC_BOTTOM 8'h00
`define TPC_MAX 8'hFF

// timer_sync_prescaler_reset_control fields
`define TPC_SYNC_HOLD_BIT 7
`define TPC_ASY_RST_BIT 1
`define TPC_SH_RST_BIT 0

// control_a_reg fields
`define TPC_COMA_HI 7
`define TPC_COMA_LO 6
`define TPC_COMB_HI 5
`define TPC_COMB_LO 4
`define TPC_WGM1_BIT 1
`define TPC_WGM0_BIT 0

// control_b_reg fields
`define TPC_FOCA_BIT 7
`define TPC_FOCB_BIT 6
`define TPC_WGM2_BIT 3
`define TPC_CS_HI 2
`define TPC_CS_LO 0

// async_status_reg field
`define TPC_AS_BIT 5

// irq_flag_reg / irq_mask_reg fields
`define TPC_OCFB_BIT 2
`define TPC_OCFA_BIT 1
`define TPC_TOV_BIT 0

// waveform modes
`define TPC_WM_NORMAL 3'h0
`define TPC_WM_PC_MAX 3'h1
`define TPC_WM_CTC 3'h2
`define TPC_WM_FAST_MAX 3'h3
`define TPC_WM_PC_CMPA 3'h5
`define TPC_WM_FAST_CMPA 3'h7

// clock select codes
`define TPC_CS_STOP 3'h0
`define TPC_CS_DIV1 3'h1
`define TPC_CS_DIV8 3'h2
`define TPC_CS_DIV32 3'h3
`define TPC_CS_DIV64 3'h4
`define TPC_CS_DIV128 3'h5
`define TPC_CS_DIV256 3'h6

// compare output actions
`define TPC_COM_NONE 2'h0
`define TPC_COM_TOGGLE 2'h1
`define TPC_COM_CLEAR 2'h2
`define TPC_COM_SET 2'h3

`endif

// >>> tpc_timer2_core.v
// Purpose: counter unit of the 8-bit timer2 with prescaler reset / sync hold control
// Assumes: cpu bus on clk_in, crystal pin is asynchronous and far slower than clk_in
// Notes: register reads answer one cycle after the read strobe
//
// What this block does
// (R1) while sync hold is one, written prescaler reset bits are kept and held
// (R2) writing sync hold from one to zero clears both prescaler reset bits together
// (R3) writing async prescaler reset resets this timer's prescaler, then clears
// (R4) in async clock mode the bit stays one until the prescaler reset completes
// (R5) async prescaler reset bit is never auto-cleared while sync hold is set
// (R6) shared prescaler reset drives the other timers' prescaler, self-clears unless held
// (R7) control register answers at data offset 0x43 and i/o offset 0x23
// (R8) bottom at 0x00, max at 0xFF, top is 0xFF or compare a by mode
// (R9) counter and both compare registers are 8 bits wide
// (R10) every interrupt request has a flag and an individual mask bit
// (R11) clock select zero gives no timer tick, counter stays stopped
// (R12) tick comes from io clock by default, from crystal pins when async selected
// (R13) each tick clears, increments or decrements per mode; direction picks inc/dec
// (R14) cpu reads and writes the counter whether or not the tick runs
// (R15) a cpu counter write wins over clear or count in the same cycle
// (R16) three-bit wave mode: two low bits in control a, high bit in control b
// (R17) each compare register is matched against the counter, setting flag and output
// (R18) overflow flag is set per wave mode and can raise an interrupt
// (R19) clear forces every counter bit to zero
// (R20) in normal mode overflow flag sets on the tick that wraps to zero
`timescale 1ns/1ps
`include "tpc_timer2_regs.vh"

module tpc_timer2_core #(
	parameter PSC_W = 10
) (
	input wire clk_in,
	input wire resetn_in,
	input wire [7:0] addr_in,
	input wire io_space_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [7:0] wdata_in,
	input wire [2:0] irq_ack_in,
	input wire crystal_pin_in,
	output wire [7:0] rdata_out,
	output wire shared_prescaler_reset_out,
	output wire crystal_pin_out,
	output wire compare_output_a_out,
	output wire compare_output_b_out,
	output wire irq_ovf_out,
	output wire irq_cmpa_out,
	output wire irq_cmpb_out,
	output wire counter_bottom_out,
	output wire counter_max_out,
	output wire counter_top_out,
	output wire timer_tick_out
);

	// prescaler tap mask per clock select; a tap fires when masked bits are all ones
	function [PSC_W-1:0] tap_mask;
		input [2:0] cs;
		begin
			case (cs)
				`TPC_CS_DIV8: tap_mask = {{(PSC_W-3){1'b0}}, 3'h7};
				`TPC_CS_DIV32: tap_mask = {{(PSC_W-5){1'b0}}, 5'h1F};
				`TPC_CS_DIV64: tap_mask = {{(PSC_W-6){1'b0}}, 6'h3F};
				`TPC_CS_DIV128: tap_mask = {{(PSC_W-7){1'b0}}, 7'h7F};
				`TPC_CS_DIV256: tap_mask = {{(PSC_W-8){1'b0}}, 8'hFF};
				`TPC_CS_DIV1: tap_mask = {PSC_W{1'b0}};
				default: tap_mask = {PSC_W{1'b1}};
			endcase
		end
	endfunction

	// top value: compare a in the ctc and cmpa-topped pwm modes, else max
	function [7:0] top_val;
		input [2:0] mode;
		input [7:0] cmpa;
		begin
			if (mode == `TPC_WM_CTC || mode == `TPC_WM_PC_CMPA || mode == `TPC_WM_FAST_CMPA)
				top_val = cmpa; // R8
			else
				top_val = `TPC_MAX; // R8
		end
	endfunction

	// next state of one compare output
	function wave_next;
		input oc;
		input [1:0] com;
		input [2:0] mode;
		input match;
		input wrap;
		input dir_up;
		input force_it;
		reg pwm_fast;
		reg pwm_pc;
		begin
			pwm_fast = (mode == `TPC_WM_FAST_MAX) || (mode == `TPC_WM_FAST_CMPA);
			pwm_pc = (mode == `TPC_WM_PC_MAX) || (mode == `TPC_WM_PC_CMPA);
			wave_next = oc;
			if (pwm_fast) begin
				if (com == `TPC_COM_CLEAR && match)
					wave_next = 1'b0;
				else if (com == `TPC_COM_CLEAR && wrap)
					wave_next = 1'b1;
				else if (com == `TPC_COM_SET && match)
					wave_next = 1'b1;
				else if (com == `TPC_COM_SET && wrap)
					wave_next = 1'b0;
			end else if (pwm_pc) begin
				if (com == `TPC_COM_CLEAR && match)
					wave_next = ~dir_up;
				else if (com == `TPC_COM_SET && match)
					wave_next = dir_up;
			end else if (match || force_it) begin
				case (com)
					`TPC_COM_TOGGLE: wave_next = ~oc;
					`TPC_COM_CLEAR: wave_next = 1'b0;
					`TPC_COM_SET: wave_next = 1'b1;
					default: wave_next = oc;
				endcase
			end
		end
	endfunction

	reg [7:0] ctla_q, ctla_d, ctlb_q, ctlb_d;
	reg [7:0] cnt_q, cnt_d, cmpa_q, cmpa_d, cmpb_q, cmpb_d;
	reg [2:0] flag_q, flag_d, mask_q, mask_d;
	reg as_q, as_d;
	reg hold_q, hold_d, asy_rst_q, asy_rst_d, sh_rst_q, sh_rst_d;
	reg [PSC_W-1:0] psc_q, psc_d;
	reg dir_up_q, dir_up_d;
	reg blk_q, blk_d;
	reg oca_q, ocb_q;
	reg xs1_q, xs2_q, xs3_q;
	reg xout_q;
	reg [7:0] rdata_q;
	reg [2:0] irq_q;
	reg bottom_q, max_q, top_q, tick_q;
	reg [7:0] rd_mux;
	reg [2:0] flag_set;
	reg clr_cnt;

	wire [7:0] eff_addr;
	wire wr_sync, wr_ctla, wr_ctlb, wr_cnt, wr_cmpa, wr_cmpb, wr_ast, wr_flag, wr_mask;
	wire [2:0] mode, cs;
	wire [7:0] top;
	wire asy_edge, src_tick, tick, match_a, match_b, wrap;

	// i/o space addresses sit below data space by a fixed offset
	assign eff_addr = io_space_in ? (addr_in + `TPC_IO_OFS) : addr_in; // R7
	assign wr_sync = wr_en_in && (eff_addr == `TPC_SYNCRST_ADDR); // R7
	assign wr_ctla = wr_en_in && (eff_addr == `TPC_CTLA_ADDR);
	assign wr_ctlb = wr_en_in && (eff_addr == `TPC_CTLB_ADDR);
	assign wr_cnt = wr_en_in && (eff_addr == `TPC_CNT_ADDR); // R14
	assign wr_cmpa = wr_en_in && (eff_addr == `TPC_CMPA_ADDR);
	assign wr_cmpb = wr_en_in && (eff_addr == `TPC_CMPB_ADDR);
	assign wr_ast = wr_en_in && (eff_addr == `TPC_ASTAT_ADDR);
	assign wr_flag = wr_en_in && (eff_addr == `TPC_FLAG_ADDR);
	assign wr_mask = wr_en_in && (eff_addr == `TPC_MASK_ADDR);

	assign mode = {ctlb_q[`TPC_WGM2_BIT], ctla_q[`TPC_WGM1_BIT], ctla_q[`TPC_WGM0_BIT]}; // R16
	assign cs = ctlb_q[`TPC_CS_HI:`TPC_CS_LO];
	assign top = top_val(mode, cmpa_q);

	// crystal edge seen only after the two-stage synchroniser
	assign asy_edge = xs2_q & ~xs3_q;
	assign src_tick = as_q ? asy_edge : 1'b1; // R12
	// a pending async prescaler reset (held or not) stops the tick; the shared one does not
	assign tick = (cs != `TPC_CS_STOP) && !asy_rst_q && src_tick
		&& ((psc_q & tap_mask(cs)) == tap_mask(cs)); // R11
	// a counter write blocks compare matches for one timer tick
	assign match_a = tick && !blk_q && (cnt_q == cmpa_q); // R17
	assign match_b = tick && !blk_q && (cnt_q == cmpb_q); // R17
	assign wrap = tick && (mode == `TPC_WM_FAST_MAX || mode == `TPC_WM_FAST_CMPA)
		&& (cnt_q == top);

	// prescaler reset control
	always @* begin
		hold_d = hold_q;
		asy_rst_d = asy_rst_q;
		sh_rst_d = sh_rst_q;
		if (wr_sync) begin
			hold_d = wdata_in[`TPC_SYNC_HOLD_BIT];
			if (hold_q && !wdata_in[`TPC_SYNC_HOLD_BIT]) begin
				asy_rst_d = 1'b0; // R2
				sh_rst_d = 1'b0; // R2
			end else begin
				asy_rst_d = wdata_in[`TPC_ASY_RST_BIT]; // R1
				sh_rst_d = wdata_in[`TPC_SH_RST_BIT]; // R1
			end
		end else if (!hold_q) begin
			sh_rst_d = 1'b0; // R6
			// async mode: cleared only once the reset reached the prescaler
			if (asy_rst_q && src_tick)
				asy_rst_d = 1'b0; // R3 R4 R5
		end
	end

	always @* begin
		psc_d = psc_q;
		if (src_tick) begin
			if (asy_rst_q)
				psc_d = {PSC_W{1'b0}}; // R3
			else
				psc_d = psc_q + {{(PSC_W-1){1'b0}}, 1'b1};
		end
	end

	// counter: cpu write, then clear, then count
	always @* begin
		cnt_d = cnt_q;
		dir_up_d = dir_up_q;
		clr_cnt = 1'b0;
		flag_set = 3'h0;
		flag_set[`TPC_OCFA_BIT] = match_a; // R17
		flag_set[`TPC_OCFB_BIT] = match_b; // R17
		if (tick) begin
			case (mode)
				`TPC_WM_PC_MAX, `TPC_WM_PC_CMPA: begin
					if (dir_up_q) begin
						if (cnt_q == top) begin
							dir_up_d = 1'b0; // R13
							cnt_d = cnt_q - 8'h01;
						end else begin
							cnt_d = cnt_q + 8'h01;
						end
					end else begin
						if (cnt_q == `TPC_BOTTOM) begin
							dir_up_d = 1'b1; // R13
							cnt_d = cnt_q + 8'h01;
							flag_set[`TPC_TOV_BIT] = 1'b1; // R18
						end else begin
							cnt_d = cnt_q - 8'h01; // R13
						end
					end
				end
				`TPC_WM_CTC: begin
					dir_up_d = 1'b1;
					clr_cnt = (cnt_q == top); // R13
					cnt_d = cnt_q + 8'h01;
					flag_set[`TPC_TOV_BIT] = (cnt_q == `TPC_MAX); // R18
				end
				`TPC_WM_FAST_MAX, `TPC_WM_FAST_CMPA: begin
					dir_up_d = 1'b1;
					clr_cnt = (cnt_q == top); // R13
					cnt_d = cnt_q + 8'h01;
					flag_set[`TPC_TOV_BIT] = (cnt_q == top); // R18
				end
				default: begin
					// normal and reserved codes count up and wrap
					dir_up_d = 1'b1;
					cnt_d = cnt_q + 8'h01; // R13
					flag_set[`TPC_TOV_BIT] = (cnt_q == `TPC_MAX); // R20
				end
			endcase
			if (clr_cnt)
				cnt_d = `TPC_BOTTOM; // R19
		end
		if (wr_cnt)
			cnt_d = wdata_in; // R15
	end

	// config registers and flags; hardware set wins over a clearing write
	always @* begin
		ctla_d = wr_ctla ? wdata_in : ctla_q;
		ctlb_d = ctlb_q;
		if (wr_ctlb) begin
			ctlb_d = wdata_in;
			ctlb_d[`TPC_FOCA_BIT] = 1'b0; // force bits are strobes, never stored
			ctlb_d[`TPC_FOCB_BIT] = 1'b0;
		end
		cmpa_d = wr_cmpa ? wdata_in : cmpa_q; // R9
		cmpb_d = wr_cmpb ? wdata_in : cmpb_q; // R9
		as_d = wr_ast ? wdata_in[`TPC_AS_BIT] : as_q; // R12
		mask_d = mask_q;
		if (wr_mask) begin
			mask_d[`TPC_OCFB_BIT] = wdata_in[`TPC_OCFB_BIT];
			mask_d[`TPC_OCFA_BIT] = wdata_in[`TPC_OCFA_BIT];
			mask_d[`TPC_TOV_BIT] = wdata_in[`TPC_TOV_BIT];
		end
		flag_d = flag_q & ~irq_ack_in;
		if (wr_flag)
			flag_d = flag_d & ~wdata_in[2:0];
		flag_d = flag_d | flag_set; // R10
		blk_d = blk_q;
		if (wr_cnt)
			blk_d = 1'b1;
		else if (tick)
			blk_d = 1'b0;
	end

	always @* begin
		rd_mux = `TPC_RESET_VAL;
		case (eff_addr)
			`TPC_SYNCRST_ADDR: begin
				rd_mux[`TPC_SYNC_HOLD_BIT] = hold_q;
				rd_mux[`TPC_ASY_RST_BIT] = asy_rst_q;
				rd_mux[`TPC_SH_RST_BIT] = sh_rst_q;
			end
			`TPC_CTLA_ADDR: rd_mux = ctla_q;
			`TPC_CTLB_ADDR: rd_mux = ctlb_q;
			`TPC_CNT_ADDR: rd_mux = cnt_q; // R14
			`TPC_CMPA_ADDR: rd_mux = cmpa_q;
			`TPC_CMPB_ADDR: rd_mux = cmpb_q;
			`TPC_ASTAT_ADDR: rd_mux[`TPC_AS_BIT] = as_q;
			`TPC_FLAG_ADDR: rd_mux[2:0] = flag_q;
			`TPC_MASK_ADDR: rd_mux[2:0] = mask_q;
			default: rd_mux = `TPC_RESET_VAL;
		endcase
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			xs1_q <= 1'b0;
			xs2_q <= 1'b0;
			xs3_q <= 1'b0;
			xout_q <= 1'b0;
		end else begin
			xs1_q <= crystal_pin_in;
			xs2_q <= xs1_q;
			xs3_q <= xs2_q;
			xout_q <= ~xs2_q;
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hold_q <= 1'b0;
			asy_rst_q <= 1'b0;
			sh_rst_q <= 1'b0;
			psc_q <= {PSC_W{1'b0}};
			ctla_q <= `TPC_RESET_VAL;
			ctlb_q <= `TPC_RESET_VAL;
			cnt_q <= `TPC_RESET_VAL;
			cmpa_q <= `TPC_RESET_VAL;
			cmpb_q <= `TPC_RESET_VAL;
			as_q <= 1'b0;
			flag_q <= 3'h0;
			mask_q <= 3'h0;
			dir_up_q <= 1'b1;
			blk_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			asy_rst_q <= asy_rst_d;
			sh_rst_q <= sh_rst_d;
			psc_q <= psc_d;
			ctla_q <= ctla_d;
			ctlb_q <= ctlb_d;
			cnt_q <= cnt_d;
			cmpa_q <= cmpa_d;
			cmpb_q <= cmpb_d;
			as_q <= as_d;
			flag_q <= flag_d;
			mask_q <= mask_d;
			dir_up_q <= dir_up_d;
			blk_q <= blk_d;
		end
	end

	// outputs registered; status bits track the counter value being stored
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= `TPC_RESET_VAL;
			irq_q <= 3'h0;
			oca_q <= 1'b0;
			ocb_q <= 1'b0;
			bottom_q <= 1'b1;
			max_q <= 1'b0;
			top_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			if (rd_en_in)
				rdata_q <= rd_mux;
			irq_q <= flag_d & mask_d; // R10
			oca_q <= wave_next(oca_q, ctla_q[`TPC_COMA_HI:`TPC_COMA_LO], mode, match_a,
				wrap, dir_up_q, wr_ctlb && wdata_in[`TPC_FOCA_BIT]); // R17
			ocb_q <= wave_next(ocb_q, ctla_q[`TPC_COMB_HI:`TPC_COMB_LO], mode, match_b,
				wrap, dir_up_q, wr_ctlb && wdata_in[`TPC_FOCB_BIT]); // R17
			bottom_q <= (cnt_d == `TPC_BOTTOM); // R8
			max_q <= (cnt_d == `TPC_MAX); // R8
			top_q <= (cnt_d == top_val({ctlb_d[`TPC_WGM2_BIT], ctla_d[`TPC_WGM1_BIT],
				ctla_d[`TPC_WGM0_BIT]}, cmpa_d)); // R8
			tick_q <= tick;
		end
	end

	assign rdata_out = rdata_q;
	assign shared_prescaler_reset_out = sh_rst_q; // R6
	assign crystal_pin_out = xout_q;
	assign compare_output_a_out = oca_q;
	assign compare_output_b_out = ocb_q;
	assign irq_ovf_out = irq_q[`TPC_TOV_BIT]; // R18
	assign irq_cmpa_out = irq_q[`TPC_OCFA_BIT];
	assign irq_cmpb_out = irq_q[`TPC_OCFB_BIT];
	assign counter_bottom_out = bottom_q;
	assign counter_max_out = max_q;
	assign counter_top_out = top_q;
	assign timer_tick_out = tick_q;

endmodule // tpc_timer2_core

// >>> tpc_timer2_props.sv
// Purpose: port-level checks of the timer2 counter core
// Assumes: data-space map of the register header
// Notes: helpers shadow cpu writes only, never the count
`timescale 1ns/1ps
`include "tpc_timer2_regs.vh"
module tpc_timer2_props #(
	parameter PSC_W = 10
) (
	input wire clk_in,
	input wire resetn_in,
	input wire [7:0] addr_in,
	input wire io_space_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [7:0] wdata_in,
	input wire [7:0] rdata_out,
	input wire shared_prescaler_reset_out,
	input wire irq_ovf_out,
	input wire irq_cmpa_out,
	input wire irq_cmpb_out,
	input wire counter_bottom_out,
	input wire counter_max_out,
	input wire timer_tick_out
);
	wire [7:0] ea = io_space_in ? addr_in + `TPC_IO_OFS : addr_in;
	wire wsync = wr_en_in && ea == `TPC_SYNCRST_ADDR;
	wire wcnt = wr_en_in && ea == `TPC_CNT_ADDR;
	wire mapped = ea == `TPC_SYNCRST_ADDR || ea[7:3] == 5'h1A;
	reg hold_q;
	reg [2:0] cs_q;
	reg [2:0] mask_q;
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hold_q <= 1'b0;
			cs_q <= 3'h0;
			mask_q <= 3'h0;
		end else if (wr_en_in) begin
			if (ea == `TPC_SYNCRST_ADDR)
				hold_q <= wdata_in[7];
			if (ea == `TPC_CTLB_ADDR)
				cs_q <= wdata_in[2:0];
			if (ea == `TPC_MASK_ADDR)
				mask_q <= wdata_in[2:0];
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	a_bottom_on_write: assert property (wcnt |=> counter_bottom_out == ($past(wdata_in) == 8'h00))
		else $error("bottom flag does not follow counter write");
	a_max_on_write: assert property (wcnt |=> counter_max_out == ($past(wdata_in) == 8'hFF))
		else $error("max flag does not follow counter write");
	a_stop_no_tick: assert property ((cs_q == 3'h0) [*4] |-> !timer_tick_out)
		else $error("tick with clock select zero");
	a_shared_pulse: assert property (wsync && !hold_q && wdata_in[0] && !wdata_in[7] |=> shared_prescaler_reset_out ##1 !shared_prescaler_reset_out)
		else $error("shared prescaler reset not a single pulse");
	a_hold_keeps: assert property (hold_q && shared_prescaler_reset_out && !wsync |=> shared_prescaler_reset_out)
		else $error("held prescaler reset dropped");
	a_hold_release: assert property (wsync && hold_q && !wdata_in[7] |=> !shared_prescaler_reset_out)
		else $error("prescaler reset kept after hold release");
	a_irq_masked: assert property (({irq_cmpb_out, irq_cmpa_out, irq_ovf_out} & ~(mask_q | $past(mask_q))) == 3'h0)
		else $error("masked interrupt raised");
	a_unmapped_zero: assert property (rd_en_in && !mapped |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_sync_rsvd: assert property (rd_en_in && ea == `TPC_SYNCRST_ADDR |=> rdata_out[6:2] == 5'h00)
		else $error("reserved sync bits read nonzero");
endmodule // tpc_timer2_props
bind tpc_timer2_core tpc_timer2_props #(.PSC_W(PSC_W)) i_props (.clk_in(clk_in),
	.resetn_in(resetn_in), .addr_in(addr_in), .io_space_in(io_space_in), .wr_en_in(wr_en_in),
	.rd_en_in(rd_en_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
	.shared_prescaler_reset_out(shared_prescaler_reset_out), .irq_ovf_out(irq_ovf_out),
	.irq_cmpa_out(irq_cmpa_out), .irq_cmpb_out(irq_cmpb_out),
	.counter_bottom_out(counter_bottom_out), .counter_max_out(counter_max_out),
	.timer_tick_out(timer_tick_out));

// >>> tpc_cpu_model.sv
// Purpose: cpu side of the timer register bus
// Assumes: every task waits one edge first, so strobes never collide
// Notes: write data is inverted once released
`timescale 1ns/1ps
module tpc_cpu_model (
	input wire clk_in,
	input wire [7:0] rdata_in,
	output reg [7:0] addr_out,
	output reg io_space_out,
	output reg wr_en_out,
	output reg rd_en_out,
	output reg [7:0] wdata_out,
	output reg [2:0] irq_ack_out
);
	initial begin
		addr_out = 8'h00;
		io_space_out = 1'b0;
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		wdata_out = 8'h00;
		irq_ack_out = 3'h0;
	end
	task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] v);
		@(posedge clk_in);
		addr_out <= a;
		io_space_out <= io;
		wdata_out <= v;
		wr_en_out <= 1'b1;
		@(posedge clk_in);
		wr_en_out <= 1'b0;
		wdata_out <= ~v;
	endtask
	task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] v);
		@(posedge clk_in);
		addr_out <= a;
		io_space_out <= io;
		rd_en_out <= 1'b1;
		@(posedge clk_in);
		rd_en_out <= 1'b0;
		@(posedge clk_in);
		v = rdata_in;
	endtask
	task automatic ack(input logic [2:0] m);
		@(posedge clk_in);
		irq_ack_out <= m;
		@(posedge clk_in);
		irq_ack_out <= 3'h0;
	endtask
endmodule // tpc_cpu_model

// >>> timer2_counter_prescaler_ctl_tb_top.sv
// Purpose: self-checking bench for the timer2 counter core
// Assumes: 200 MHz clock, cpu model owns the register bus
// Notes: running counts are checked against bounds, not exact cycles
`timescale 1ns/1ps
`include "tpc_timer2_regs.vh"
module timer2_counter_prescaler_ctl_tb_top;
	reg clk_in = 1'b0;
	reg resetn_in = 1'b0;
	reg xtal = 1'b0;
	wire [7:0] addr, wdata, rdata;
	wire io_sp, wr_en, rd_en, sh_rst, bot, mx, tick, i_ovf, i_cmpa, i_cmpb;
	wire xo, oca, ocb, top_o;
	wire [2:0] ack;
	int fail_count = 0;
	int n_compared = 0;
	int i;
	logic [7:0] d;
	logic [7:0] mdl [256] = '{default: 8'h00};
	logic [7:0] amap [10] = '{8'h43, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'h50};
	logic [7:0] vals [3];
	logic [2:0] modes [3] = '{3'h2, 3'h5, 3'h7};
	always #2.5 clk_in = ~clk_in;
	tpc_timer2_core #(.PSC_W(10)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr),
		.io_space_in(io_sp), .wr_en_in(wr_en), .rd_en_in(rd_en), .wdata_in(wdata),
		.irq_ack_in(ack), .crystal_pin_in(xtal), .rdata_out(rdata),
		.shared_prescaler_reset_out(sh_rst), .crystal_pin_out(xo), .compare_output_a_out(oca),
		.compare_output_b_out(ocb), .irq_ovf_out(i_ovf), .irq_cmpa_out(i_cmpa),
		.irq_cmpb_out(i_cmpb), .counter_bottom_out(bot), .counter_max_out(mx),
		.counter_top_out(top_o), .timer_tick_out(tick));
	tpc_cpu_model i_cpu (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
		.io_space_out(io_sp), .wr_en_out(wr_en), .rd_en_out(rd_en), .wdata_out(wdata),
		.irq_ack_out(ack));
	function automatic logic [7:0] msk(input logic [7:0] a);
		case (a)
			`TPC_CTLA_ADDR: return 8'hF3;
			`TPC_CTLB_ADDR: return 8'h0F;
			`TPC_CNT_ADDR, `TPC_CMPA_ADDR, `TPC_CMPB_ADDR: return 8'hFF;
			`TPC_ASTAT_ADDR: return 8'h20;
			`TPC_MASK_ADDR: return 8'h07;
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_le(input logic [7:0] got, input logic [7:0] lim);
		n_compared++;
		if ((^got === 1'bx) || got > lim) begin
			fail_count++;
			$display("wrong value at %0t: got %h above %h", $time, got, lim);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] v);
		i_cpu.wr(a, 1'b0, v);
		mdl[a] = v;
	endtask
	task automatic rc(input logic [7:0] a);
		logic [7:0] r;
		i_cpu.rd(a, 1'b0, r);
		chk(r, mdl[a] & msk(a));
	endtask
	task automatic conclude;
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		conclude();
	end
	initial begin
		i = $urandom(19184);
		repeat (5) @(posedge clk_in);
		resetn_in <= 1'b1;
		foreach (amap[k]) rc(amap[k]);
		w(`TPC_CMPA_ADDR, 8'($urandom));
		rc(`TPC_CMPA_ADDR);
		w(`TPC_CMPB_ADDR, 8'($urandom));
		rc(`TPC_CMPB_ADDR);
		// hold keeps both reset bits, reached through the i/o alias
		i_cpu.wr(8'h23, 1'b1, 8'h83);
		repeat (4) @(posedge clk_in);
		chk({7'h00, sh_rst}, 8'h01);
		i_cpu.rd(8'h23, 1'b1, d);
		chk(d, 8'h83);
		i_cpu.wr(`TPC_SYNCRST_ADDR, 1'b0, 8'h00);
		#1 chk({7'h00, sh_rst}, 8'h00);
		rc(`TPC_SYNCRST_ADDR);
		i_cpu.wr(`TPC_SYNCRST_ADDR, 1'b0, 8'h01);
		#1 chk({7'h00, sh_rst}, 8'h01);
		@(posedge clk_in);
		#1 chk({7'h00, sh_rst}, 8'h00);
		i_cpu.wr(`TPC_SYNCRST_ADDR, 1'b0, 8'h02);
		repeat (2) @(posedge clk_in);
		rc(`TPC_SYNCRST_ADDR);
		// async source: bit waits for a crystal edge
		w(`TPC_ASTAT_ADDR, 8'h20);
		i_cpu.wr(`TPC_SYNCRST_ADDR, 1'b0, 8'h02);
		repeat (3) @(posedge clk_in);
		i_cpu.rd(`TPC_SYNCRST_ADDR, 1'b0, d);
		chk(d, 8'h02);
		xtal <= 1'b1;
		repeat (6) @(posedge clk_in);
		#1 chk({7'h00, xo}, 8'h00);
		xtal <= 1'b0;
		repeat (6) @(posedge clk_in);
		#1 chk({7'h00, xo}, 8'h01);
		rc(`TPC_SYNCRST_ADDR);
		w(`TPC_ASTAT_ADDR, 8'h00);
		vals = '{8'($urandom), 8'h00, 8'hFF};
		foreach (vals[k]) begin
			w(`TPC_CNT_ADDR, vals[k]);
			#1 chk({5'h00, top_o, mx, bot}, {5'h00, vals[k] == 8'hFF, vals[k] == 8'hFF,
				vals[k] == 8'h00});
			repeat (20) @(posedge clk_in);
			rc(`TPC_CNT_ADDR);
		end
		// normal mode wrap with compare a on the way, b off the path
		w(`TPC_MASK_ADDR, 8'h07);
		w(`TPC_CMPA_ADDR, 8'h05);
		w(`TPC_CMPB_ADDR, 8'h80);
		w(`TPC_CNT_ADDR, 8'hF8);
		w(`TPC_CTLB_ADDR, 8'h01);
		repeat (20) @(posedge clk_in);
		w(`TPC_CTLB_ADDR, 8'h00);
		i_cpu.rd(`TPC_CNT_ADDR, 1'b0, d);
		chk_le(d, 8'h20);
		i_cpu.rd(`TPC_FLAG_ADDR, 1'b0, d);
		chk(d, 8'h03);
		chk({5'h00, i_cmpb, i_cmpa, i_ovf}, 8'h03);
		i_cpu.ack(3'h2);
		i_cpu.rd(`TPC_FLAG_ADDR, 1'b0, d);
		chk(d, 8'h01);
		i_cpu.wr(`TPC_FLAG_ADDR, 1'b0, 8'h01);
		i_cpu.rd(`TPC_FLAG_ADDR, 1'b0, d);
		chk(d, 8'h00);
		// force strobes toggle both outputs while stopped in normal mode
		w(`TPC_CTLA_ADDR, 8'h50);
		w(`TPC_CTLB_ADDR, 8'hC0);
		#1 chk({6'h00, ocb, oca}, 8'h03);
		// top at compare a in ctc and in both cmpa-topped pwm modes
		w(`TPC_CMPA_ADDR, 8'h20);
		foreach (modes[k]) begin
			w(`TPC_CNT_ADDR, 8'h00);
			w(`TPC_CTLA_ADDR, {6'h00, modes[k][1:0]});
			w(`TPC_CTLB_ADDR, {4'h0, modes[k][2], 3'h1});
			repeat (4) begin
				repeat (50) @(posedge clk_in);
				i_cpu.rd(`TPC_CNT_ADDR, 1'b0, d);
				chk_le(d, 8'h20);
			end
			w(`TPC_CNT_ADDR, 8'h00);
			#1 chk({7'h00, bot}, 8'h01);
		end
		w(`TPC_CTLB_ADDR, 8'h00);
		w(`TPC_MASK_ADDR, 8'h00);
		conclude();
	end
endmodule // timer2_counter_prescaler_ctl_tb_top
